/* verilog/lsf_status.sv */
// LIN status flags, error detail, control strobes and interrupt logic.
// Assumes a frame engine on sys_clk giving one-cycle event pulses and
// a LIN receive pin from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_params.svh"

// Notes on behaviour
// [RL1] Bit 7 follows activity seen on the LIN bus.
// [RL2] Slave: bit 6 set after four quiet seconds while not asleep.
// [RL3] Slave: bit 5 set by a break during an unfinished transmission.
// [RL4] Slave: bit 5 also set by a stop-processing write.
// [RL5] Bit 5 cleared by a break that interrupts nothing.
// [RL6] Slave: bit 4 set once a data identifier arrives.
// [RL7] Bit 3 high while an interrupt is pending; cleared by reset strobe.
// [RL8] Bit 2 set on any error; cleared only by error-reset strobe.
// [RL9] Bit 1 high while sending wakeup or after receiving one.
// [RL10] Bit 0 cleared at each transmission start; low before any.
// [RL11] Bit 0 set when the current transmission finishes.
// [RL12] Status sits at 0x09, read-only, resets to zero.
// [RL13] Interrupt-reset bit clears bit 3, reads zero, zero does nothing.
// [RL14] Error-reset bit clears status and detail errors, reads zero.
// [RL15] Stop-processing write ignores communication until next break.
// [RL16] Host writes to the status register are ignored.
// [RL17] Any detail error bit set also raises the status error flag.
module lsf_status #(
    parameter int unsigned IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             lin_rx,
    input  wire logic             slave_mode,
    input  wire logic             sleep_state,
    input  wire logic             frame_active,
    input  wire logic             break_det,
    input  wire logic             xfer_start,
    input  wire logic             xfer_done,
    input  wire logic             data_id_rx,
    input  wire logic             ctrl_irq_event,
    input  wire lsf_pkg::lsf_err_t err_event,
    input  wire logic             wakeup_tx,
    input  wire logic             wakeup_rx,
    input  wire logic [7:0]       reg_addr,
    input  wire lsf_pkg::lsf_byte_t reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output lsf_pkg::lsf_byte_t    reg_rdata,
    output lsf_pkg::lsf_byte_t    lin_bus_status,
    output logic                  stop_hold,
    output logic                  irq
);
    import lsf_pkg::*;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] target);
        hit = (a == target);
    endfunction

    logic ctrl_wr;
    logic ist_rd;
    logic mask_wr;

    assign ctrl_wr = reg_wr && hit(reg_addr, `LSF_ADDR_CTRL);
    assign ist_rd  = reg_rd && hit(reg_addr, `LSF_ADDR_IRQ_STAT);
    assign mask_wr = reg_wr && hit(reg_addr, `LSF_ADDR_IRQ_MASK);

    // Control bits act only as one-cycle strobes and are never stored.
    logic stop_wr;
    logic dtack_wr;
    logic interrupt_clear_strobe_wr;
    logic error_clear_strobe_wr;

    assign stop_wr   = ctrl_wr && reg_wdata[`LSF_CTRL_STOP] && slave_mode;
    assign dtack_wr  = ctrl_wr && reg_wdata[`LSF_CTRL_DTACK];
    assign interrupt_clear_strobe_wr = ctrl_wr && reg_wdata[`LSF_CTRL_INTERRUPT_CLEAR_STROBE]; // RL13
    assign error_clear_strobe_wr = ctrl_wr && reg_wdata[`LSF_CTRL_ERROR_CLEAR_STROBE]; // RL14

    // ------------------------------------------------------------------
    // Receive pin synchroniser and activity
    // ------------------------------------------------------------------
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_last_r;
    logic rx_edge;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_last_r <= 1'b1;
        end else begin
            rx_meta_r <= lin_rx;
            rx_sync_r <= rx_meta_r;
            rx_last_r <= rx_sync_r;
        end
    end

    assign rx_edge = rx_sync_r ^ rx_last_r;

    logic active_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active_r <= 1'b0;
        end else begin
            active_r <= frame_active || !rx_sync_r; // RL1
        end
    end

    // ------------------------------------------------------------------
    // Stop processing hold
    // ------------------------------------------------------------------
    // Start, done, data identifier and error events are masked while the hold stands; breaks are not.
    logic live;

    assign live = !stop_hold;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stop_hold <= 1'b0;
        end else if (stop_wr) begin
            stop_hold <= 1'b1; // RL15
        end else if (break_det) begin
            stop_hold <= 1'b0; // RL15
        end
    end

    // ------------------------------------------------------------------
    // Idle timeout
    // ------------------------------------------------------------------
    logic idle_timeout;

    lsf_idle_timer #(
        .IDLE_CYCLES (IDLE_CYCLES)
    ) u_idle (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .enable   (slave_mode && !sleep_state), // RL2
        .activity (rx_edge || frame_active),
        .timeout  (idle_timeout)
    );

    // ------------------------------------------------------------------
    // Transmission tracking, abort and done
    // ------------------------------------------------------------------
    logic busy_r;
    logic abort_r;
    logic done_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else if (live && xfer_start) begin
            busy_r <= 1'b1;
        end else if (break_det || (live && xfer_done)) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            abort_r <= 1'b0;
        end else if (stop_wr) begin
            abort_r <= 1'b1; // RL4
        end else if (break_det && slave_mode && busy_r) begin
            abort_r <= 1'b1; // RL3
        end else if (break_det && !busy_r) begin
            abort_r <= 1'b0; // RL5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else if (live && xfer_done) begin
            done_r <= 1'b1; // RL11
        end else if (live && xfer_start) begin
            done_r <= 1'b0; // RL10
        end
    end

    // ------------------------------------------------------------------
    // Data request
    // ------------------------------------------------------------------
    logic dreq_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dreq_r <= 1'b0;
        end else if (live && slave_mode && data_id_rx) begin
            dreq_r <= 1'b1; // RL6
        end else if (dtack_wr || break_det) begin
            dreq_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pending flag
    // ------------------------------------------------------------------
    logic int_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_r <= 1'b0;
        end else if (ctrl_irq_event) begin
            int_r <= 1'b1; // RL7
        end else if (interrupt_clear_strobe_wr) begin
            int_r <= 1'b0; // RL13
        end
    end

    // ------------------------------------------------------------------
    // Error detail and error flag
    // ------------------------------------------------------------------
    lsf_err_t err_r;
    lsf_err_t err_in;
    logic     err_flag_r;

    assign err_in = live ? err_event : `LSF_ERR_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `LSF_ERR_W; gi++) begin : g_err
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    err_r[gi] <= 1'b0;
                end else if (err_in[gi]) begin
                    err_r[gi] <= 1'b1;
                end else if (error_clear_strobe_wr) begin
                    err_r[gi] <= 1'b0; // RL14
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            err_flag_r <= 1'b0;
        end else if (|err_in) begin
            err_flag_r <= 1'b1; // RL8 RL17
        end else if (error_clear_strobe_wr) begin
            err_flag_r <= 1'b0; // RL8 RL14
        end
    end

    // ------------------------------------------------------------------
    // Wakeup
    // ------------------------------------------------------------------
    logic wake_seen_r;
    logic wake_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_seen_r <= 1'b0;
        end else if (wakeup_rx) begin
            wake_seen_r <= 1'b1;
        end else if (break_det) begin
            wake_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wakeup_tx || wakeup_rx || wake_seen_r; // RL9
        end
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    lsf_byte_t status_nxt;

    always_comb begin
        status_nxt                = `LSF_STATUS_RST;
        status_nxt[`LSF_ST_ACTIVE] = active_r;
        status_nxt[`LSF_ST_IDLE]   = idle_timeout && slave_mode; // RL2
        status_nxt[`LSF_ST_ABORT]  = abort_r;
        status_nxt[`LSF_ST_DREQ]   = dreq_r;
        status_nxt[`LSF_ST_INT]    = int_r;
        status_nxt[`LSF_ST_ERR]    = err_flag_r;
        status_nxt[`LSF_ST_WAKE]   = wake_r;
        status_nxt[`LSF_ST_DONE]   = done_r;
    end

    // Only internal flags feed this register; bus writes never reach it.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lin_bus_status <= `LSF_STATUS_RST; // RL12
        end else begin
            lin_bus_status <= status_nxt; // RL16
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------------
    lsf_irq_t ist_r;
    lsf_irq_t ist_set;
    lsf_irq_t ist_nxt;
    lsf_irq_t mask_r;
    logic     idle_last_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            idle_last_r <= 1'b0;
        end else begin
            idle_last_r <= idle_timeout;
        end
    end

    always_comb begin
        ist_set                 = `LSF_IRQ_RST;
        ist_set[`LSF_IRQ_DONE]  = live && xfer_done;
        ist_set[`LSF_IRQ_DREQ]  = live && slave_mode && data_id_rx;
        ist_set[`LSF_IRQ_ERR]   = |err_in;
        ist_set[`LSF_IRQ_WAKE]  = wakeup_rx;
        ist_set[`LSF_IRQ_IDLE]  = idle_timeout && !idle_last_r;
        ist_set[`LSF_IRQ_ABORT] = stop_wr ||
                                  (break_det && slave_mode && busy_r);
        // A read clears the sticky bits, but a new event in that cycle stays.
        ist_nxt = (ist_rd ? `LSF_IRQ_RST : ist_r) | ist_set;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ist_r <= `LSF_IRQ_RST;
        end else begin
            ist_r <= ist_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask_r <= `LSF_IRQ_RST;
        end else if (mask_wr) begin
            mask_r <= reg_wdata[`LSF_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ist_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    lsf_byte_t rd_nxt;

    always_comb begin
        rd_nxt = 8'h00;
        unique case (reg_addr)
            `LSF_ADDR_STATUS:   rd_nxt = status_nxt; // RL12
            `LSF_ADDR_ERROR:    rd_nxt = {3'h0, err_r};
            `LSF_ADDR_IRQ_STAT: rd_nxt = {2'h0, ist_r};
            `LSF_ADDR_IRQ_MASK: rd_nxt = {2'h0, mask_r};
            default:            rd_nxt = 8'h00; // RL13 RL14
        endcase
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // lsf_status

`default_nettype wire

/* verilog/lsf_params.svh */
// Constants of the LIN status flag block: offsets, bit positions, counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef LSF_PARAMS_SVH
`define LSF_PARAMS_SVH

// ----------------------------------------------------------------------
// Indirect register addresses
// ----------------------------------------------------------------------
`define LSF_ADDR_CTRL     8'h08
`define LSF_ADDR_STATUS   8'h09
`define LSF_ADDR_ERROR    8'h0a
`define LSF_ADDR_IRQ_STAT 8'h10
`define LSF_ADDR_IRQ_MASK 8'h11

// ----------------------------------------------------------------------
// Status register bits and reset value
// ----------------------------------------------------------------------
`define LSF_ST_ACTIVE 7
`define LSF_ST_IDLE   6
`define LSF_ST_ABORT  5
`define LSF_ST_DREQ   4
`define LSF_ST_INT    3
`define LSF_ST_ERR    2
`define LSF_ST_WAKE   1
`define LSF_ST_DONE   0
`define LSF_STATUS_RST 8'h00

// ----------------------------------------------------------------------
// Control register strobe bits
// ----------------------------------------------------------------------
`define LSF_CTRL_STOP   7
`define LSF_CTRL_DTACK  4
`define LSF_CTRL_INTERRUPT_CLEAR_STROBE 3
`define LSF_CTRL_ERROR_CLEAR_STROBE 2

// ----------------------------------------------------------------------
// Error detail and interrupt layouts
// ----------------------------------------------------------------------
`define LSF_ERR_W      5
`define LSF_ERR_RST    5'h00
`define LSF_IRQ_W      6
`define LSF_IRQ_RST    6'h00
`define LSF_IRQ_DONE   0
`define LSF_IRQ_DREQ   1
`define LSF_IRQ_ERR    2
`define LSF_IRQ_WAKE   3
`define LSF_IRQ_IDLE   4
`define LSF_IRQ_ABORT  5

// ----------------------------------------------------------------------
// Bus idle timeout
// ----------------------------------------------------------------------
`define LSF_IDLE_TIME_MS 4000
`define LSF_CLK_KHZ      40000
`define LSF_IDLE_CYCLES  (`LSF_IDLE_TIME_MS * `LSF_CLK_KHZ)
`define LSF_IDLE_CNT_W   28

`endif

/* verilog/lsf_pkg.sv */
// Types shared by the LIN status flag block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lsf_pkg;
    typedef logic [7:0] lsf_byte_t;
    typedef logic [4:0] lsf_err_t;
    typedef logic [5:0] lsf_irq_t;
endpackage

`default_nettype wire

/* verilog/lsf_idle_timer.sv */
// Bus idle timer: flags a bus that stayed quiet for the idle period.
// Assumes an activity pulse from synchronised bus logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_params.svh"

module lsf_idle_timer #(
    parameter int unsigned IDLE_CYCLES = `LSF_IDLE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic enable,
    input  wire logic activity,
    output logic      timeout
);
    localparam logic [`LSF_IDLE_CNT_W-1:0] LAST =
        `LSF_IDLE_CNT_W'(IDLE_CYCLES - 1);

    logic [`LSF_IDLE_CNT_W-1:0] count_r;

    // The count restarts on any activity and stops when it reaches the end.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !enable || activity) begin
            count_r <= '0;
        end else if (count_r != LAST) begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !enable || activity) begin
            timeout <= 1'b0;
        end else if (count_r == LAST) begin
            timeout <= 1'b1;
        end
    end
endmodule // lsf_idle_timer

`default_nettype wire

/* bench/lsf_status_sva.sv */
// Concurrent checks on the ports of the LIN status flag block.
// Assumes one sys_clk domain with synchronous sys_rst, bound below.
`timescale 1ns/1ps
`default_nettype none

module lsf_status_sva #(
    parameter int unsigned IDLE_CYCLES = 50
) (
    input wire logic               sys_clk,
    input wire logic               sys_rst,
    input wire logic               slave_mode,
    input wire logic               sleep_state,
    input wire logic               frame_active,
    input wire logic               break_det,
    input wire logic               xfer_start,
    input wire logic               xfer_done,
    input wire logic               ctrl_irq_event,
    input wire lsf_pkg::lsf_err_t  err_event,
    input wire logic               wakeup_tx,
    input wire logic [7:0]         reg_addr,
    input wire lsf_pkg::lsf_byte_t reg_wdata,
    input wire logic               reg_wr,
    input wire lsf_pkg::lsf_byte_t reg_rdata,
    input wire lsf_pkg::lsf_byte_t lin_bus_status,
    input wire logic               stop_hold
);
    import lsf_pkg::*;
    logic ctl_wr;
    assign ctl_wr = reg_wr && reg_addr == 8'h08;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reset_all_zero: assert property (
        $past(sys_rst) |-> lin_bus_status == 8'h00 && !stop_hold
        && reg_rdata == 8'h00) else $error("outputs not zero after reset");
    a_active_seen: assert property (
        frame_active |-> ##2 lin_bus_status[7])
        else $error("activity flag missing");
    a_done_set: assert property (
        xfer_done && !stop_hold |-> ##2 lin_bus_status[0])
        else $error("done flag not set");
    a_start_clears: assert property (
        xfer_start && !xfer_done && !stop_hold |=> ##1 !lin_bus_status[0])
        else $error("done flag not cleared at start");
    a_int_set: assert property (
        ctrl_irq_event |-> ##2 lin_bus_status[3])
        else $error("interrupt flag not set");
    a_int_clear: assert property (
        ctl_wr && reg_wdata[3] && !ctrl_irq_event |-> ##2 !lin_bus_status[3])
        else $error("interrupt flag not cleared");
    a_err_set: assert property (
        (|err_event) && !stop_hold |-> ##2 lin_bus_status[2])
        else $error("error flag not set");
    a_err_sticky: assert property (
        lin_bus_status[2] && !$past(ctl_wr && reg_wdata[2])
        |=> lin_bus_status[2]) else $error("error flag dropped");
    a_stop_holds: assert property (
        ctl_wr && reg_wdata[7] && slave_mode |=> stop_hold)
        else $error("stop hold not raised");
    a_stop_abort: assert property (
        ctl_wr && reg_wdata[7] && slave_mode |-> ##2 lin_bus_status[5])
        else $error("abort flag not set by stop");
    a_stop_leave: assert property (
        stop_hold && break_det && !(ctl_wr && reg_wdata[7]) |=> !stop_hold)
        else $error("stop hold kept after break");
    a_wake_tx: assert property (
        wakeup_tx |-> ##2 lin_bus_status[1])
        else $error("wakeup flag missing");
    a_idle_gated: assert property (
        sleep_state || !slave_mode |-> ##2 !lin_bus_status[6])
        else $error("idle flag set while asleep or master");
endmodule // lsf_status_sva

bind lsf_status lsf_status_sva #(.IDLE_CYCLES(IDLE_CYCLES)) u_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .slave_mode(slave_mode),
    .sleep_state(sleep_state),
    .frame_active(frame_active), .break_det(break_det),
    .xfer_start(xfer_start), .xfer_done(xfer_done),
    .ctrl_irq_event(ctrl_irq_event), .err_event(err_event),
    .wakeup_tx(wakeup_tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .lin_bus_status(lin_bus_status), .stop_hold(stop_hold));

`default_nettype wire

/* bench/lsf_lin_node.sv */
// Other node on the LIN bus: drives a dominant break on request.
// Assumes the bus pull-up, so the line rests recessive (high).
`timescale 1ns/1ps
`default_nettype none

module lsf_lin_node #(
    parameter int unsigned BRK_CYC = 20
) (
    input  wire logic sys_clk,
    input  wire logic send_brk,
    output logic      lin_rx
);
    int unsigned cnt = 0;
    always_ff @(posedge sys_clk) begin
        if (send_brk) begin
            cnt <= BRK_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign lin_rx = (cnt == 0);
endmodule // lsf_lin_node

`default_nettype wire

/* bench/lsf_status_bench.sv */
// Self-checking bench of the LIN status flag block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module lsf_status_bench;
    import lsf_pkg::*;
    localparam int unsigned IDLE_N = 50;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       slave_mode = 1'b0;
    logic       sleep_state = 1'b0;
    logic       frame_active = 1'b0;
    logic       wakeup_tx = 1'b0;
    logic       send_brk = 1'b0;
    logic [5:0] ev = 6'h00;
    lsf_err_t   err_event = 5'h00;
    logic [7:0] reg_addr = 8'h00;
    lsf_byte_t  reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    lsf_byte_t  reg_rdata;
    lsf_byte_t  lin_bus_status;
    lsf_byte_t  d;
    logic       stop_hold;
    logic       irq;
    wire        lin_rx;
    int         error_cnt = 0;
    int         n_tests = 0;

    always #12.5 sys_clk = ~sys_clk;

    lsf_lin_node u_node (.sys_clk(sys_clk), .send_brk(send_brk),
        .lin_rx(lin_rx));
    lsf_status #(.IDLE_CYCLES(IDLE_N)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .lin_rx(lin_rx),
        .slave_mode(slave_mode), .sleep_state(sleep_state),
        .frame_active(frame_active), .break_det(ev[4]),
        .xfer_start(ev[0]), .xfer_done(ev[1]), .data_id_rx(ev[2]),
        .ctrl_irq_event(ev[3]), .err_event(err_event),
        .wakeup_tx(wakeup_tx), .wakeup_rx(ev[5]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lin_bus_status(lin_bus_status),
        .stop_hold(stop_hold), .irq(irq));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input lsf_byte_t seen, input lsf_byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input lsf_byte_t v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output lsf_byte_t v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        tick(1);
    endtask
    task automatic fire(input int i);
        ev[i] <= 1'b1;
        tick(1);
        ev[i] <= 1'b0;
        tick(2);
    endtask
    // Reads the status register and compares one flag.
    task automatic st(input int b, input logic e);
        lsf_byte_t v;
        rd(8'h09, v);
        chk({7'h00, v[b]}, {7'h00, e});
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(8'h09, d);
        chk(d, 8'h00);
        wr(8'h09, 8'hff);
        rd(8'h09, d);
        chk(d, 8'h00);
        rd(8'h3f, d);
        chk(d, 8'h00);
        wr(8'h08, 8'h0c);
        rd(8'h08, d);
        chk(d, 8'h00);
    endtask
    task automatic t_done;
        wr(8'h11, 8'h01);
        fire(0);
        st(0, 1'b0);
        fire(1);
        st(0, 1'b1);
        chk({7'h00, irq}, 8'h01);
        rd(8'h10, d);
        chk(d, 8'h01);
        tick(1);
        #1;
        chk({7'h00, irq}, 8'h00);
        fire(0);
        st(0, 1'b0);
    endtask
    task automatic t_flags;
        fire(3);
        st(3, 1'b1);
        wr(8'h08, 8'h00);
        st(3, 1'b1);
        wr(8'h08, 8'h08);
        st(3, 1'b0);
        err_event <= 5'h02;
        tick(1);
        err_event <= 5'h00;
        tick(2);
        st(2, 1'b1);
        rd(8'h0a, d);
        chk(d, 8'h02);
        wr(8'h08, 8'h04);
        st(2, 1'b0);
        rd(8'h0a, d);
        chk(d, 8'h00);
    endtask
    task automatic t_slave;
        slave_mode <= 1'b1;
        fire(0);
        fire(4);
        st(5, 1'b1);
        fire(1);
        fire(4);
        st(5, 1'b0);
        wr(8'h08, 8'h80);
        chk({7'h00, stop_hold}, 8'h01);
        st(5, 1'b1);
        fire(2);
        st(4, 1'b0);
        fire(4);
        chk({7'h00, stop_hold}, 8'h00);
        fire(2);
        st(4, 1'b1);
        wr(8'h08, 8'h10);
        st(4, 1'b0);
    endtask
    task automatic t_idle;
        tick(IDLE_N + 10);
        st(6, 1'b1);
        sleep_state <= 1'b1;
        tick(2);
        st(6, 1'b0);
        sleep_state <= 1'b0;
        send_brk <= 1'b1;
        tick(1);
        send_brk <= 1'b0;
        tick(8);
        st(7, 1'b1);
        st(6, 1'b0);
        tick(60);
        st(7, 1'b0);
        frame_active <= 1'b1;
        tick(3);
        st(7, 1'b1);
        frame_active <= 1'b0;
    endtask
    task automatic t_wake;
        wakeup_tx <= 1'b1;
        tick(3);
        st(1, 1'b1);
        wakeup_tx <= 1'b0;
        tick(3);
        st(1, 1'b0);
        fire(5);
        st(1, 1'b1);
    endtask

    initial begin
        tick(10);
        sys_rst <= 1'b0;
        tick(1);
        t_regs();
        t_done();
        t_flags();
        t_slave();
        t_idle();
        t_wake();
        stop_test();
    end
endmodule // lsf_status_bench

`default_nettype wire
